// ===== hw/tccr_pkg.sv
// package: register map, field positions and reset values of the timer block
// Operation
// - overflow flag set on overflow only while both serial clock selects clear
// - external event flag set when trigger falling edge causes capture or reload
// - external event flag with interrupt enabled requests the timer interrupt outside up/down mode
// - in up/down mode the external event flag raises no interrupt
// - receive clock select routes this overflow to receiver, else timer 1 overflow
// - transmit clock select routes this overflow to transmitter, else timer 1 overflow
// - trigger enable and no serial clocking: trigger falling edge captures or reloads
// - timer counts only while run control is set
// - select clear counts internal clock, set counts count pin falling edges
// - serial clocking forces auto-reload on overflow, capture select ignored
// - reload mode reloads on overflow and on enabled trigger falling edge
// - capture mode with trigger enable captures count on trigger falling edge
package tccr_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0] TCCR_OFF_COUNT   = 8'h00;
    localparam logic [7:0] TCCR_OFF_RELOAD  = 8'h04;
    localparam logic [7:0] TCCR_OFF_STATUS  = 8'h08;
    localparam logic [7:0] TCCR_OFF_MASK    = 8'h0c;
    localparam logic [7:0] TCCR_OFF_MODE    = 8'h10;
    localparam logic [7:0] TCCR_OFF_CONTROL = 8'hc8;

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int TCCR_CTL_OVF  = 7;
    localparam int TCCR_CTL_EXT  = 6;
    localparam int TCCR_CTL_RCLK = 5;
    localparam int TCCR_CTL_TRANSMIT_CLOCK_SELECT = 4;
    localparam int TCCR_CTL_TEN  = 3;
    localparam int TCCR_CTL_RUN  = 2;
    localparam int TCCR_CTL_CT   = 1;
    localparam int TCCR_CTL_CP   = 0;

    // ****************************************************************
    // status, mask and mode fields
    // ****************************************************************
    localparam int TCCR_ST_OVF   = 0;
    localparam int TCCR_ST_EXT   = 1;
    localparam int TCCR_ST_W     = 2;
    localparam int TCCR_MODE_DIR = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0]  TCCR_RST_CONTROL = 8'h00;
    localparam logic [15:0] TCCR_RST_COUNT   = 16'h0000;
    localparam logic [15:0] TCCR_RST_RELOAD  = 16'h0000;
    localparam logic [1:0]  TCCR_RST_STATUS  = 2'h0;
    localparam logic [1:0]  TCCR_RST_MASK    = 2'h0;
    localparam logic [31:0] TCCR_RST_RDATA   = 32'h0000_0000;

endpackage

// ===== hw/tccr_fall_detect.sv
// falling edge detectors for the synchronous external pins
`timescale 1ns/10ps
module tccr_fall_detect #(
    parameter int WIDTH = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin,
    output wire logic [WIDTH-1:0] fall
);

    // ****************************************************************
    // one history flop per pin
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic last;
            // reset high so a pin held low at release is seen as one falling edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    last <= 1'b1;
                end else begin
                    last <= pin[i];
                end
            end
            assign fall[i] = last & ~pin[i];
        end
    endgenerate

endmodule

// ===== hw/tccr_timer.sv
// timer two: counter, capture/reload, serial baud select, flags and apb slave
`timescale 1ns/10ps
module tccr_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    input  wire logic        count_pin,
    input  wire logic        trigger_pin,
    input  wire logic        timer1_overflow,
    output wire logic        rx_baud_tick,
    output wire logic        tx_baud_tick,
    output wire logic        irq
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]       timer_two_control;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] capture_reload;
    logic [1:0]       irq_status;
    logic [1:0]       irq_mask;
    logic             direction_count_enable;

    wire logic overflow_flag         = timer_two_control[tccr_pkg::TCCR_CTL_OVF];
    wire logic external_event_flag   = timer_two_control[tccr_pkg::TCCR_CTL_EXT];
    wire logic receive_clock_select  = timer_two_control[tccr_pkg::TCCR_CTL_RCLK];
    wire logic transmit_clock_select = timer_two_control[tccr_pkg::TCCR_CTL_TRANSMIT_CLOCK_SELECT];
    wire logic trigger_enable        = timer_two_control[tccr_pkg::TCCR_CTL_TEN];
    wire logic run_control           = timer_two_control[tccr_pkg::TCCR_CTL_RUN];
    wire logic counter_timer_select  = timer_two_control[tccr_pkg::TCCR_CTL_CT];
    wire logic capture_reload_select = timer_two_control[tccr_pkg::TCCR_CTL_CP];

    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire logic setup_rd = psel & ~penable & ~pwrite;
    wire logic access   = psel & penable;
    wire logic hit_cnt  = paddr == tccr_pkg::TCCR_OFF_COUNT;
    wire logic hit_rld  = paddr == tccr_pkg::TCCR_OFF_RELOAD;
    wire logic hit_st   = paddr == tccr_pkg::TCCR_OFF_STATUS;
    wire logic hit_msk  = paddr == tccr_pkg::TCCR_OFF_MASK;
    wire logic hit_mode = paddr == tccr_pkg::TCCR_OFF_MODE;
    wire logic hit_ctl  = paddr == tccr_pkg::TCCR_OFF_CONTROL;
    wire logic hit_any  = hit_cnt | hit_rld | hit_st | hit_msk | hit_mode | hit_ctl;
    wire logic wr       = access & pwrite;
    wire logic wr_cnt   = wr & hit_cnt;
    wire logic wr_rld   = wr & hit_rld;
    wire logic wr_st    = wr & hit_st;
    wire logic wr_msk   = wr & hit_msk;
    wire logic wr_mode  = wr & hit_mode;
    wire logic wr_ctl   = wr & hit_ctl;

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;

    wire logic [31:0] rd_mux =
        hit_cnt  ? {{(32-CNT_W){1'b0}}, count} :
        hit_rld  ? {{(32-CNT_W){1'b0}}, capture_reload} :
        hit_st   ? {30'h0, irq_status} :
        hit_msk  ? {30'h0, irq_mask} :
        hit_mode ? {31'h0, direction_count_enable} :
        hit_ctl  ? {24'h0, timer_two_control} :
        tccr_pkg::TCCR_RST_RDATA;

    // ****************************************************************
    // pin edges
    // ****************************************************************
    logic [1:0] falls;

    tccr_fall_detect #(
        .WIDTH (2)
    ) tccr_fall_detect_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({trigger_pin, count_pin}),
        .fall    (falls)
    );

    wire logic count_fall   = falls[0];
    wire logic trigger_fall = falls[1];

    // ****************************************************************
    // counting and events
    // ****************************************************************
    wire logic [CNT_W-1:0] all_ones = {CNT_W{1'b1}};
    wire logic baud_mode  = receive_clock_select | transmit_clock_select;
    // counter select must stay clear in clock-out mode; not checked here
    wire logic tick       = run_control & (counter_timer_select ? count_fall : 1'b1);
    wire logic ovf_evt    = tick & (count == all_ones);
    wire logic cap_mode   = capture_reload_select & ~baud_mode;
    wire logic trig_evt   = trigger_fall & trigger_enable & ~baud_mode;
    wire logic cap_evt    = trig_evt & cap_mode;
    wire logic trig_rld   = trig_evt & ~cap_mode;
    wire logic ovf_rld    = ovf_evt & ~cap_mode;
    wire logic ovf_set    = ovf_evt & ~baud_mode;
    wire logic ext_set    = trig_evt;

    // software write wins over counting; trigger reload wins over a tick
    wire logic [CNT_W-1:0] next_count =
        wr_cnt             ? pwdata[CNT_W-1:0] :
        (ovf_rld | trig_rld) ? capture_reload :
        tick               ? count + 1'b1 :
        count;

    // a capture is an event and beats a software write
    wire logic [CNT_W-1:0] next_capture_reload =
        cap_evt ? count :
        wr_rld  ? pwdata[CNT_W-1:0] :
        capture_reload;

    // ****************************************************************
    // serial baud clocks
    // ****************************************************************
    assign rx_baud_tick = receive_clock_select  ? ovf_evt : timer1_overflow;
    assign tx_baud_tick = transmit_clock_select ? ovf_evt : timer1_overflow;

    // ****************************************************************
    // control register: hardware set beats software clear of the flags
    // ****************************************************************
    wire logic [7:0] ctl_base = wr_ctl ? pwdata[7:0] : timer_two_control;
    wire logic [7:0] ctl_set  = {ovf_set, ext_set, 6'h00};
    wire logic [7:0] next_timer_two_control = ctl_base | ctl_set;

    // ****************************************************************
    // interrupts: sticky status, write one to clear, set wins
    // ****************************************************************
    // up/down mode keeps the external event off the interrupt line
    wire logic ext_irq_set = ext_set & ~direction_count_enable;
    wire logic [1:0] st_set = {ext_irq_set, ovf_set};
    wire logic [1:0] st_clr = wr_st ? pwdata[1:0] : 2'h0;
    wire logic [1:0] next_irq_status = (irq_status & ~st_clr) | st_set;
    assign irq = |(irq_status & irq_mask);

    // ****************************************************************
    // flops
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_two_control <= tccr_pkg::TCCR_RST_CONTROL;
            count             <= tccr_pkg::TCCR_RST_COUNT[CNT_W-1:0];
            capture_reload    <= tccr_pkg::TCCR_RST_RELOAD[CNT_W-1:0];
        end else begin
            timer_two_control <= next_timer_two_control;
            count             <= next_count;
            capture_reload    <= next_capture_reload;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status             <= tccr_pkg::TCCR_RST_STATUS;
            irq_mask               <= tccr_pkg::TCCR_RST_MASK;
            direction_count_enable <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (wr_msk) begin
                irq_mask <= pwdata[1:0];
            end
            if (wr_mode) begin
                direction_count_enable <= pwdata[tccr_pkg::TCCR_MODE_DIR];
            end
        end
    end

    // read data is taken in the setup cycle so it stands through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= tccr_pkg::TCCR_RST_RDATA;
        end else if (setup_rd) begin
            prdata <= rd_mux;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_ovf_flag_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        ovf_evt && !baud_mode |=> overflow_flag && irq_status[0]
    ) else $error("overflow did not set the overflow flag");

    chk_ovf_baud_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        baud_mode && !wr_ctl && !overflow_flag |=> !overflow_flag
    ) else $error("overflow flag set while clocking the serial port");

    chk_ext_flag_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        trigger_fall && trigger_enable && !baud_mode |=> external_event_flag
    ) else $error("trigger event did not set the external event flag");

    chk_ext_irq_raise: assert property (
        @(posedge pclk) disable iff (!presetn)
        trig_evt && !direction_count_enable && irq_mask[1] && !wr_msk |=> irq
    ) else $error("external event did not raise the interrupt");

    chk_updown_no_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        direction_count_enable && !irq_status[1] |=> !irq_status[1]
    ) else $error("external event interrupt in up/down mode");

    chk_rx_baud_src: assert property (
        @(posedge pclk) disable iff (!presetn)
        receive_clock_select && rx_baud_tick |-> run_control && count == all_ones
    ) else $error("receive baud tick without timer overflow");

    chk_tx_baud_src: assert property (
        @(posedge pclk) disable iff (!presetn)
        !transmit_clock_select |-> tx_baud_tick == timer1_overflow
    ) else $error("transmit baud tick not from timer 1");

    chk_trig_ignored: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!trigger_enable || baud_mode) && !wr_ctl && !external_event_flag
        |=> !external_event_flag
    ) else $error("trigger pin event not ignored");

    chk_run_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        !run_control && !wr_cnt && !trig_rld |=> $stable(count)
    ) else $error("count moved while stopped");

    chk_timer_inc: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_control && !counter_timer_select && !wr_cnt && !trig_rld
        && count != all_ones |=> count == $past(count) + 1'b1
    ) else $error("timer mode did not increment");

    chk_baud_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        ovf_evt && baud_mode && !wr_cnt |=> count == $past(capture_reload)
    ) else $error("no auto-reload in baud mode");

    chk_trig_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        trig_evt && !capture_reload_select && !wr_cnt
        |=> count == $past(capture_reload)
    ) else $error("trigger did not reload the count");

    chk_capture_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        trig_evt && capture_reload_select |=> capture_reload == $past(count)
    ) else $error("capture register missed the count");

    chk_cap_wrap: assert property (
        @(posedge pclk) disable iff (!presetn)
        ovf_evt && cap_mode && !wr_cnt |=> count == '0
    ) else $error("capture mode overflow did not wrap to zero");

    cov_reload_ovf: cover property (
        @(posedge pclk) disable iff (!presetn) ovf_rld && !baud_mode);
    cov_capture: cover property (
        @(posedge pclk) disable iff (!presetn) cap_evt);
    cov_baud_tick: cover property (
        @(posedge pclk) disable iff (!presetn) rx_baud_tick && receive_clock_select);
    cov_irq_rise: cover property (
        @(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule

// ===== dv/tccr_pin_model.sv
// pin and serial port model facing the timer: count, trigger and timer one pins
`timescale 1ns/10ps
module tccr_pin_model (
    input  wire logic pclk,
    input  wire logic rx_baud_tick,
    input  wire logic tx_baud_tick,
    output logic      count_pin,
    output logic      trigger_pin,
    output logic      timer1_overflow
);
    int rx_ticks = 0;
    int tx_ticks = 0;

    // count and trigger pins idle high so no edge is seen out of reset; timer one overflow idles low
    initial begin
        count_pin       = 1'b1;
        trigger_pin     = 1'b1;
        timer1_overflow = 1'b0;
    end

    // ****************************************************************
    // serial port side: count each baud tick seen
    // ****************************************************************
    always @(posedge pclk) begin
        if (rx_baud_tick === 1'b1) begin
            rx_ticks <= rx_ticks + 1;
        end
        if (tx_baud_tick === 1'b1) begin
            tx_ticks <= tx_ticks + 1;
        end
    end

    // low for two cycles, high for two, so the synchronous detect sees it
    task automatic fall_count;
        count_pin <= 1'b0;
        repeat (2) @(posedge pclk);
        count_pin <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task automatic fall_trigger;
        trigger_pin <= 1'b0;
        repeat (2) @(posedge pclk);
        trigger_pin <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    task automatic t1_pulse;
        timer1_overflow <= 1'b1;
        @(posedge pclk);
        timer1_overflow <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
endmodule

// ===== dv/tccr_timer_test.sv
// self-checking bench for the timer two control, capture and reload block
`timescale 1ns/10ps
module tccr_timer_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        count_pin;
    logic        trigger_pin;
    logic        timer1_overflow;
    logic        rx_baud_tick;
    logic        tx_baud_tick;
    logic        irq;
    logic [31:0] rd;
    logic        rd_err;
    int          n_errors;
    int          samples_checked;

    tccr_timer #(.CNT_W(16)) tccr_timer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_pin(count_pin),
        .trigger_pin(trigger_pin), .timer1_overflow(timer1_overflow),
        .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq(irq)
    );

    tccr_pin_model tccr_pin_model_inst (
        .pclk(pclk), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
        .count_pin(count_pin), .trigger_pin(trigger_pin),
        .timer1_overflow(timer1_overflow)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ****************************************************************
    // bus and compare tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // entered just after a rising edge; waits on pready, never assumes a count
    task automatic apb(input logic is_wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) n_errors++;
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task automatic rchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(name, rd, exp);
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // whole sequence is a few hundred cycles
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        finish_test();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_errors = 0;
        samples_checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("control", tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0000);
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_0000);
        rchk("reload", tccr_pkg::TCCR_OFF_RELOAD, 32'h0000_0000);
        rchk("status", tccr_pkg::TCCR_OFF_STATUS, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check("unmapped data", rd, 32'h0000_0000);
        check("unmapped error", {31'h0, rd_err}, 32'h0000_0001);
        // timer mode: run stands for three edges between the control writes
        wr(tccr_pkg::TCCR_OFF_COUNT, 32'h0000_0100);
        // counter select clear here; the serial clock steps below set it while the timer is a clock source
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0004);
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0000);
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_0103);
        // both selects clear: timer one drives both serial clocks
        tccr_pin_model_inst.t1_pulse();
        check("rx ticks", tccr_pin_model_inst.rx_ticks, 32'h0000_0001);
        check("tx ticks", tccr_pin_model_inst.tx_ticks, 32'h0000_0001);
        // count pin mode, overflow reloads from the paired register
        wr(tccr_pkg::TCCR_OFF_RELOAD, 32'h0000_1234);
        wr(tccr_pkg::TCCR_OFF_COUNT, 32'h0000_fffe);
        wr(tccr_pkg::TCCR_OFF_MASK, 32'h0000_0001);
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0006);
        tccr_pin_model_inst.fall_count();
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_ffff);
        tccr_pin_model_inst.fall_count();
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_1234);
        rchk("control", tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0086);
        rchk("status", tccr_pkg::TCCR_OFF_STATUS, 32'h0000_0001);
        check("irq", {31'h0, irq}, 32'h0000_0001);
        wr(tccr_pkg::TCCR_OFF_STATUS, 32'h0000_0001);
        check("irq", {31'h0, irq}, 32'h0000_0000);
        // run cleared: pin edges no longer count
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0002);
        tccr_pin_model_inst.fall_count();
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_1234);
        // capture on trigger fall
        wr(tccr_pkg::TCCR_OFF_MASK, 32'h0000_0002);
        rchk("mask", tccr_pkg::TCCR_OFF_MASK, 32'h0000_0002);
        wr(tccr_pkg::TCCR_OFF_COUNT, 32'h0000_00ab);
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_000f);
        tccr_pin_model_inst.fall_trigger();
        rchk("reload", tccr_pkg::TCCR_OFF_RELOAD, 32'h0000_00ab);
        rchk("control", tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_004f);
        rchk("status", tccr_pkg::TCCR_OFF_STATUS, 32'h0000_0002);
        check("irq", {31'h0, irq}, 32'h0000_0001);
        // reload on trigger fall, up/down mode holds back the interrupt
        wr(tccr_pkg::TCCR_OFF_STATUS, 32'h0000_0002);
        wr(tccr_pkg::TCCR_OFF_MODE, 32'h0000_0001);
        rchk("mode", tccr_pkg::TCCR_OFF_MODE, 32'h0000_0001);
        wr(tccr_pkg::TCCR_OFF_RELOAD, 32'h0000_5555);
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_000e);
        tccr_pin_model_inst.fall_trigger();
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_5555);
        rchk("control", tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_004e);
        rchk("status", tccr_pkg::TCCR_OFF_STATUS, 32'h0000_0000);
        check("irq", {31'h0, irq}, 32'h0000_0000);
        // trigger enable clear: edge ignored
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0006);
        wr(tccr_pkg::TCCR_OFF_COUNT, 32'h0000_0011);
        tccr_pin_model_inst.fall_trigger();
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_0011);
        rchk("control", tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0006);
        // receive clock from this timer, capture select set but ignored
        wr(tccr_pkg::TCCR_OFF_COUNT, 32'h0000_ffff);
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_002f);
        tccr_pin_model_inst.fall_trigger();
        rchk("reload", tccr_pkg::TCCR_OFF_RELOAD, 32'h0000_5555);
        tccr_pin_model_inst.fall_count();
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_5555);
        rchk("control", tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_002f);
        check("rx ticks", tccr_pin_model_inst.rx_ticks, 32'h0000_0002);
        check("tx ticks", tccr_pin_model_inst.tx_ticks, 32'h0000_0001);
        tccr_pin_model_inst.t1_pulse();
        check("rx ticks", tccr_pin_model_inst.rx_ticks, 32'h0000_0002);
        check("tx ticks", tccr_pin_model_inst.tx_ticks, 32'h0000_0002);
        // transmit clock from this timer, receive back on timer one
        wr(tccr_pkg::TCCR_OFF_COUNT, 32'h0000_ffff);
        wr(tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0016);
        tccr_pin_model_inst.fall_count();
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_5555);
        rchk("control", tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0016);
        check("tx ticks", tccr_pin_model_inst.tx_ticks, 32'h0000_0003);
        check("rx ticks", tccr_pin_model_inst.rx_ticks, 32'h0000_0002);
        // reset in mid-run clears the registers
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("control", tccr_pkg::TCCR_OFF_CONTROL, 32'h0000_0000);
        rchk("count", tccr_pkg::TCCR_OFF_COUNT, 32'h0000_0000);
        rchk("mode", tccr_pkg::TCCR_OFF_MODE, 32'h0000_0000);
        finish_test();
    end
endmodule
